// ==== ger_pkg.sv ====
// Package of offsets, fields and constants for the identifier ROM, retry and compare-swap registers
// Operation
// R1 - Writing one to bit 31 zeroes the ROM address; hardware then clears the bit.
// R2 - Address clear leaves the fetched byte field unchanged until a read runs.
// R3 - Writing one to bit 25 starts fetching the byte at the current address.
// R4 - Hardware clears bit 25 when the fetch completes, so software can poll it.
// R5 - Fetched byte appears in bits 23 to 16, updated by hardware.
// R6 - Option ROM offset in bits 7 to 0 reads zero by default.
// R7 - Bit 5 of ROM byte 6h set makes the option ROM offset read 20h.
// R8 - Software uses the ROM access register only when the present flag reads one.
// R9 - Reserved bits 30-26, 24 and 15-8 of the ROM access register read zero.
// R10 - Dual-phase seconds and cycle limit fields, bits 31 to 16, read zero.
// R11 - Bits 11 to 8 limit physical response unit retries.
// R12 - Bits 7 to 4 limit async transmit response unit retries.
// R13 - Bits 3 to 0 limit async transmit request unit retries.
// R14 - Read-only compare-swap value register holds the word stored on a successful compare.
// R15 - Present flag at version bit 24 set on detection at reset; info block loads.
// R16 - Completion flag bit 31 set when an operation ends, cleared by any control write.
// R17 - Two-bit resource select picks one of four bus-management resources.
// R18 - Each unit counts attempts, stops at the limit, reports the last acknowledge.
package ger_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // Byte offsets of the register words
  localparam logic [7:0] GER_OFS_VERSION = 8'h00;
  localparam logic [7:0] GER_OFS_ID_ROM = 8'h04;
  localparam logic [7:0] GER_OFS_RETRY = 8'h08;
  localparam logic [7:0] GER_OFS_CS_VALUE = 8'h0c;
  localparam logic [7:0] GER_OFS_CS_CTRL = 8'h14;
  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and fixed values
  localparam int GER_BIT_ADDR_CLEAR = 31;
  localparam int GER_BIT_LAUNCH = 25;
  localparam int GER_BIT_CS_DONE = 31;
  localparam int GER_OPT_FLAG_BIT = 5;
  localparam logic [7:0] GER_OPT_BYTE_ADDR = 8'h06;
  localparam logic [7:0] GER_OPT_ROM_OFFSET = 8'h20;
  localparam logic [7:0] GER_VER_MAJOR = 8'h01;
  localparam logic [7:0] GER_VER_MINOR = 8'h10;
  localparam logic [31:0] GER_ID_RSVD_MASK = 32'h7d00ff00;
  localparam logic [31:0] GER_RETRY_RSVD_MASK = 32'hfffff000;
  localparam logic [31:0] GER_CS_CTRL_RSVD_MASK = 32'h7ffffffc;
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, counts and bus answers
  localparam logic [11:0] GER_RETRY_RESET = 12'h000;
  localparam logic GER_CS_DONE_RESET = 1'b1;
  localparam logic [1:0] GER_BOOT_SETTLE = 2'h3;
  localparam logic [1:0] GER_RESP_OKAY = 2'h0;
  localparam logic [1:0] GER_RESP_SLVERR = 2'h2;
  // Bus-management resource chosen for compare-swap
  typedef enum logic [1:0] {
    GER_RES_BUS_MANAGER_ID,
    GER_RES_BANDWIDTH_AVAILABLE,
    GER_RES_CHANNELS_AVAILABLE_HI,
    GER_RES_CHANNELS_AVAILABLE_LO
  } ger_resource_t;
endpackage : ger_pkg

// ==== ger_fetch_if.sv ====
// Interface between the register bank and the ROM byte fetch engine
`timescale 1ns/10ps
`default_nettype none
interface ger_fetch_if;
  logic start;
  logic [7:0] addr;
  logic done;
  logic [7:0] data;
  logic busy;
  modport client (output start, output addr, input done, input data, input busy);
  modport engine (input start, input addr, output done, output data, output busy);
endinterface : ger_fetch_if
`default_nettype wire

// ==== ger_rom_reader.sv ====
// Byte fetch engine toward the external serial EEPROM controller
`timescale 1ns/10ps
`default_nettype none
module ger_rom_reader (
  input wire logic clk,
  input wire logic reset_n,
  ger_fetch_if.engine fetch,
  output logic ee_req,
  output logic [7:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [7:0] ee_data
);
  import ger_pkg::*;
  typedef struct packed {
    logic req;
    logic done;
    logic [7:0] addr;
    logic [7:0] data;
  } ger_rd_st_t;
  ger_rd_st_t st_reg, st_next;
  ////////////////////////////////////////////////////////////////////////////////
  // Request held until the controller acknowledges; done is a single pulse
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (st_reg.req && ee_ack) begin
      st_next.req = 1'b0;
      st_next.done = 1'b1;
      st_next.data = ee_data;
    end else if (!st_reg.req && fetch.start) begin
      st_next.req = 1'b1;
      st_next.addr = fetch.addr;
    end
  end
  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign ee_req = st_reg.req;
  assign ee_addr = st_reg.addr;
  assign fetch.done = st_reg.done;
  assign fetch.data = st_reg.data;
  assign fetch.busy = st_reg.req;
endmodule : ger_rom_reader
`default_nettype wire

// ==== ger_retry_unit.sv ====
// Per-unit retry counter for busy or data-error acknowledges
`timescale 1ns/10ps
`default_nettype none
module ger_retry_unit #(
  parameter int LIMIT_W = 4,
  parameter int ACK_W = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [LIMIT_W-1:0] limit,
  input wire logic tx_done,
  input wire logic ack_retryable,
  input wire logic [ACK_W-1:0] ack_code,
  output logic retry_req,
  output logic final_valid,
  output logic [ACK_W-1:0] final_ack
);
  import ger_pkg::*;
  typedef struct packed {
    logic [LIMIT_W-1:0] cnt;
    logic retry;
    logic fin;
    logic [ACK_W-1:0] ack;
  } ger_ru_st_t;
  ger_ru_st_t st_reg, st_next;
  ////////////////////////////////////////////////////////////////////////////////
  // Retry while below the limit, else close the packet with its last acknowledge
  always_comb begin
    st_next = st_reg;
    st_next.retry = 1'b0;
    st_next.fin = 1'b0;
    if (tx_done) begin
      if (ack_retryable && (st_reg.cnt < limit)) begin
        st_next.retry = 1'b1; // R18
        st_next.cnt = st_reg.cnt + 1'b1;
      end else begin
        st_next.fin = 1'b1; // R18
        st_next.ack = ack_code;
        st_next.cnt = '0;
      end
    end
  end
  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign retry_req = st_reg.retry;
  assign final_valid = st_reg.fin;
  assign final_ack = st_reg.ack;
  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RETRY_BELOW_LIMIT: assert property (@(posedge clk) disable iff (!reset_n) // R18
    tx_done && ack_retryable && (st_reg.cnt < limit) |=> retry_req && !final_valid)
    else $error("retry not issued below limit");
  AST_RETRY_STOPS: assert property (@(posedge clk) disable iff (!reset_n) // R18
    tx_done && (!ack_retryable || st_reg.cnt >= limit)
    |=> final_valid && !retry_req && final_ack == $past(ack_code) && st_reg.cnt == '0)
    else $error("packet not closed at limit");
  COV_LIMIT_HIT: cover property (@(posedge clk) disable iff (!reset_n)
    retry_req ##[1:40] final_valid);
endmodule : ger_retry_unit
`default_nettype wire

// ==== guid_eeprom_retry_regs.sv ====
// Register bank for identifier ROM access, transmit retry limits and compare-swap data
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module ger_guid_eeprom_retry_regs #(
  parameter int UNITS = 3,
  parameter int ACK_W = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eeprom_detect,
  output logic bus_info_load,
  output logic ee_req,
  output logic [7:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [7:0] ee_data,
  input wire logic [UNITS-1:0] unit_tx_done,
  input wire logic [UNITS-1:0] unit_ack_retryable,
  input wire logic [UNITS*ACK_W-1:0] unit_ack_code,
  output logic [UNITS-1:0] unit_retry_req,
  output logic [UNITS-1:0] unit_final_valid,
  output logic [UNITS*ACK_W-1:0] unit_final_ack,
  input wire logic cs_op_done,
  input wire logic cs_value_load,
  input wire logic [31:0] cs_new_value,
  output logic cs_ctrl_write,
  output var ger_pkg::ger_resource_t bus_resource_select
);
  import ger_pkg::*;
  typedef struct packed {
    logic det_s1;
    logic det_s2;
    logic [1:0] settle;
    logic boot_done;
    logic present;
    logic info_load;
    logic boot_fetch;
    logic f_boot;
    logic start;
    logic [7:0] f_addr;
    logic clear_bit;
    logic launch_bit;
    logic [7:0] rom_addr;
    logic [7:0] fetched;
    logic opt_valid;
    logic [11:0] limits;
    logic cs_done;
    logic [1:0] cs_sel;
    logic cs_wr;
    logic [31:0] cs_value;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ger_top_st_t;
  ger_top_st_t st_reg;
  ger_top_st_t st_next;
  ger_fetch_if fif ();
  logic wr_go;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;
  logic [7:0] opt_offset;
  ////////////////////////////////////////////////////////////////////////////////
  // Byte fetch engine and retry units
  ger_rom_reader u_reader (
    .clk(clk),
    .reset_n(reset_n),
    .fetch(fif),
    .ee_req(ee_req),
    .ee_addr(ee_addr),
    .ee_ack(ee_ack),
    .ee_data(ee_data)
  );
  // Unit 0 request DMA, unit 1 transmit response, unit 2 physical response
  for (genvar i = 0; i < UNITS; i++) begin : g_unit
    ger_retry_unit #(.LIMIT_W(4), .ACK_W(ACK_W)) u_retry (
      .clk(clk),
      .reset_n(reset_n),
      .limit(st_reg.limits[4*i +: 4]), // R11 R12 R13
      .tx_done(unit_tx_done[i]),
      .ack_retryable(unit_ack_retryable[i]),
      .ack_code(unit_ack_code[ACK_W*i +: ACK_W]),
      .retry_req(unit_retry_req[i]),
      .final_valid(unit_final_valid[i]),
      .final_ack(unit_final_ack[ACK_W*i +: ACK_W])
    );
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Read decode; the option offset only reports once byte 6h flagged data
  assign opt_offset = st_reg.opt_valid ? GER_OPT_ROM_OFFSET : 8'h00; // R6 R7
  always_comb begin
    rd_word = 32'h00000000;
    rd_resp = GER_RESP_OKAY;
    case (s_axi_araddr)
      GER_OFS_VERSION: begin
        rd_word = {7'h00, st_reg.present, GER_VER_MAJOR, 8'h00, GER_VER_MINOR}; // R15
      end
      GER_OFS_ID_ROM: begin
        // Reserved gaps are literal zeros in the concatenation
        rd_word = {st_reg.clear_bit, 5'h00, st_reg.launch_bit, 1'b0, // R9
                   st_reg.fetched, 8'h00, opt_offset}; // R5
      end
      GER_OFS_RETRY: begin
        rd_word = {16'h0000, 4'h0, st_reg.limits}; // R10
      end
      GER_OFS_CS_VALUE: begin
        rd_word = st_reg.cs_value; // R14
      end
      GER_OFS_CS_CTRL: begin
        rd_word = {st_reg.cs_done, 29'h00000000, st_reg.cs_sel};
      end
      default: begin
        rd_resp = GER_RESP_SLVERR;
      end
    endcase
  end
  // A write commits once both address and data are held and no answer waits
  assign wr_go = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;
  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic; hardware clears come before software sets so a set wins
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.info_load = 1'b0;
    st_next.cs_wr = 1'b0;
    // Detect pin passes two flops before use
    st_next.det_s1 = eeprom_detect;
    st_next.det_s2 = st_reg.det_s1;
    // Presence caught once after reset release, when the synchroniser has filled
    if (!st_reg.boot_done) begin
      if (st_reg.settle != GER_BOOT_SETTLE) begin
        st_next.settle = st_reg.settle + 2'h1;
      end else begin
        st_next.boot_done = 1'b1;
        st_next.present = st_reg.det_s2; // R15
        st_next.info_load = st_reg.det_s2; // R15
        st_next.boot_fetch = st_reg.det_s2;
      end
    end
    // Fetch completion; a boot fetch only reads the option flag byte
    if (fif.done) begin
      if (st_reg.f_addr == GER_OPT_BYTE_ADDR) begin
        st_next.opt_valid = fif.data[GER_OPT_FLAG_BIT]; // R7
      end
      if (!st_reg.f_boot) begin
        st_next.fetched = fif.data; // R5
        st_next.launch_bit = 1'b0; // R4
        st_next.rom_addr = st_reg.rom_addr + 8'h01;
      end
    end else if (!fif.busy && !st_reg.start) begin
      if (st_reg.boot_fetch) begin
        st_next.start = 1'b1;
        st_next.f_addr = GER_OPT_BYTE_ADDR;
        st_next.f_boot = 1'b1;
        st_next.boot_fetch = 1'b0;
      end else if (st_reg.clear_bit) begin
        // Clear waits for an idle engine and leaves the fetched byte alone
        st_next.rom_addr = 8'h00; // R1 R2
        st_next.clear_bit = 1'b0; // R1
      end else if (st_reg.launch_bit && st_reg.boot_done) begin
        st_next.start = 1'b1; // R3
        st_next.f_addr = st_reg.rom_addr;
        st_next.f_boot = 1'b0;
      end
    end
    // Write address and data taken in either order
    if (s_axi_awvalid && !st_reg.aw_hold) begin
      st_next.aw_hold = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_hold) begin
      st_next.w_hold = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = GER_RESP_OKAY;
      case (st_reg.aw_addr)
        GER_OFS_VERSION, GER_OFS_CS_VALUE: begin
          // Read-only words accept the write and ignore it
        end
        GER_OFS_ID_ROM: begin
          if (st_reg.w_strb[3] && st_reg.w_data[GER_BIT_ADDR_CLEAR]) begin
            st_next.clear_bit = 1'b1; // R1
          end
          if (st_reg.w_strb[3] && st_reg.w_data[GER_BIT_LAUNCH]) begin
            st_next.launch_bit = 1'b1; // R3
          end
        end
        GER_OFS_RETRY: begin
          if (st_reg.w_strb[0]) begin
            st_next.limits[7:0] = st_reg.w_data[7:0]; // R12 R13
          end
          if (st_reg.w_strb[1]) begin
            st_next.limits[11:8] = st_reg.w_data[11:8]; // R11
          end
        end
        GER_OFS_CS_CTRL: begin
          // Any write clears the flag, whatever its strobes
          st_next.cs_done = 1'b0; // R16
          st_next.cs_wr = 1'b1;
          if (st_reg.w_strb[0]) begin
            st_next.cs_sel = st_reg.w_data[1:0]; // R17
          end
        end
        default: begin
          st_next.bresp = GER_RESP_SLVERR;
        end
      endcase
    end
    // Completion after the write so an ending operation is never lost
    if (cs_op_done) begin
      st_next.cs_done = 1'b1; // R16
    end
    if (cs_value_load) begin
      st_next.cs_value = cs_new_value; // R14
    end
    // Read channel: one outstanding read, data captured at acceptance
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_word;
      st_next.rresp = rd_resp;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // State register; flags with a documented set reset value follow
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.limits <= GER_RETRY_RESET;
      st_reg.cs_done <= GER_CS_DONE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready = !st_reg.aw_hold;
  assign s_axi_wready = !st_reg.w_hold;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign bus_info_load = st_reg.info_load;
  assign cs_ctrl_write = st_reg.cs_wr;
  assign bus_resource_select = ger_resource_t'(st_reg.cs_sel); // R17
  assign fif.start = st_reg.start;
  assign fif.addr = st_reg.f_addr;
  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking ger_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // A write to the same word in that cycle is left out: a software set wins
  AST_CLEAR_ZEROES_ADDR: assert property ( // R1
    st_reg.clear_bit && !fif.busy && !fif.done && !st_reg.start && !st_reg.boot_fetch
    && !(wr_go && st_reg.aw_addr == GER_OFS_ID_ROM)
    |=> !st_reg.clear_bit && st_reg.rom_addr == 8'h00)
    else $error("address clear did not finish");
  AST_CLEAR_KEEPS_BYTE: assert property ( // R2
    st_reg.clear_bit && !fif.done
    |=> $stable(st_reg.fetched))
    else $error("address clear changed fetched byte");
  AST_LAUNCH_STARTS: assert property ( // R3
    st_reg.launch_bit && !st_reg.clear_bit && st_reg.boot_done && !st_reg.boot_fetch
    && !fif.busy && !fif.done && !st_reg.start
    |=> st_reg.start ##1 ee_req)
    else $error("launch did not start a fetch");
  AST_LAUNCH_CLEARS: assert property ( // R4
    fif.done && !st_reg.f_boot && !(wr_go && st_reg.aw_addr == GER_OFS_ID_ROM)
    |=> !st_reg.launch_bit)
    else $error("launch bit not cleared on completion");
  AST_BYTE_LOADED: assert property ( // R5
    ee_req && ee_ack && !st_reg.f_boot ##1 fif.done
    |=> st_reg.fetched == $past(ee_data, 2))
    else $error("fetched byte not loaded");
  AST_OPT_DEFAULT: assert property ( // R6
    s_axi_arvalid && s_axi_arready && s_axi_araddr == GER_OFS_ID_ROM
    && !st_reg.opt_valid
    |=> s_axi_rdata[7:0] == 8'h00)
    else $error("option offset not zero");
  AST_OPT_FROM_BYTE6: assert property ( // R7
    fif.done && st_reg.f_addr == GER_OPT_BYTE_ADDR
    |=> st_reg.opt_valid == $past(fif.data[GER_OPT_FLAG_BIT]))
    else $error("option flag set without byte 6h bit 5");
  AST_ID_RSVD_ZERO: assert property ( // R9
    s_axi_arvalid && s_axi_arready && s_axi_araddr == GER_OFS_ID_ROM
    |=> (s_axi_rdata & GER_ID_RSVD_MASK) == 32'h00000000)
    else $error("reserved identifier bits not zero");
  AST_DUAL_PHASE_ZERO: assert property ( // R10
    s_axi_arvalid && s_axi_arready && s_axi_araddr == GER_OFS_RETRY
    |=> (s_axi_rdata & GER_RETRY_RSVD_MASK) == 32'h00000000)
    else $error("dual-phase fields not zero");
  AST_PRESENT_LOADS: assert property ( // R15
    $rose(st_reg.present)
    |-> bus_info_load ##1 !bus_info_load)
    else $error("info block load missing");
  AST_CS_DONE_SET: assert property ( // R16
    cs_op_done |=> st_reg.cs_done)
    else $error("completion flag not set");
  AST_CS_DONE_CLEAR: assert property ( // R16
    wr_go && st_reg.aw_addr == GER_OFS_CS_CTRL && !cs_op_done
    |=> !st_reg.cs_done && cs_ctrl_write)
    else $error("completion flag not cleared by write");
  COV_ROM_READ: cover property (
    st_reg.launch_bit ##[1:40] !st_reg.launch_bit);
  COV_ADDR_CLEAR: cover property ($fell(st_reg.clear_bit));
  COV_CS_DONE: cover property (
    cs_ctrl_write ##[1:20] st_reg.cs_done);
  COV_OPT_ROM: cover property ($rose(st_reg.opt_valid));
endmodule : ger_guid_eeprom_retry_regs
`default_nettype wire

// ==== ger_eeprom_model.sv ====
// Serial identifier EEPROM stand-in answering single byte fetches
`timescale 1ns/10ps
`default_nettype none
module ger_eeprom_model (
  input wire logic clk,
  input wire logic ee_req,
  input wire logic [7:0] ee_addr,
  output logic ee_ack,
  output logic [7:0] ee_data
);
  int seed = 7;
  int wait_n = 0;
  initial begin
    ee_ack = 1'b0;
    ee_data = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Answer after 0 to 3 cycles, so both prompt and slow fetches are seen
  always @(posedge clk) begin
    if (ee_req && !ee_ack && wait_n == 0) begin
      ee_ack <= 1'b1;
      ee_data <= {ee_addr[4:0], ee_addr[7:5]} ^ 8'h5a;
      wait_n = $random(seed) & 3;
    end else begin
      if (ee_req && !ee_ack) wait_n = wait_n - 1;
      ee_ack <= 1'b0;
      ee_data <= ~ee_data; // Data lines are not valid outside the acknowledge
    end
  end
endmodule : ger_eeprom_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the identifier ROM, retry limit and compare-swap registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ger_pkg::*;
  logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, eeprom_detect;
  logic bus_info_load, ee_req, ee_ack, cs_op_done, cs_value_load, cs_ctrl_write;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ee_addr, ee_data, ptr, last_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, cs_new_value, rd, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [2:0] unit_tx_done, unit_ack_retryable, unit_retry_req, unit_final_valid;
  logic [11:0] unit_ack_code, unit_final_ack;
  ger_resource_t bus_resource_select;
  int fail_count = 0;
  int n_tests = 0;
  int seed = 32'ha8c4;
  int loads = 0, cs_writes = 0;
  int lim [3];
  int cnt [3];
  int i, u, t;
  ger_guid_eeprom_retry_regs u_dut (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .eeprom_detect, .bus_info_load, .ee_req, .ee_addr, .ee_ack, .ee_data, .unit_tx_done,
    .unit_ack_retryable, .unit_ack_code, .unit_retry_req, .unit_final_valid, .unit_final_ack,
    .cs_op_done, .cs_value_load, .cs_new_value, .cs_ctrl_write, .bus_resource_select
  );
  ger_eeprom_model u_rom (.clk, .ee_req, .ee_addr, .ee_ack, .ee_data);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pulse counters for the info load and control write outputs
  always @(posedge clk) if (bus_info_load === 1'b1) loads++;
  always @(posedge clk) if (cs_ctrl_write === 1'b1) cs_writes++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] rom_byte(input logic [7:0] a);
    return {a[4:0], a[7:5]} ^ 8'h5a;
  endfunction : rom_byte
  // Expected identifier word from the ROM model
  function automatic logic [31:0] id_word();
    logic [7:0] b6;
    b6 = rom_byte(8'h06);
    return {8'h00, last_byte, 8'h00, b6[5] ? 8'h20 : 8'h00};
  endfunction : id_word
  // Each channel drops at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  // Bounded poll of a self-clearing bit
  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      rd_reg(GER_OFS_ID_ROM);
      k++;
    end while (rd[b] !== 1'b0 && k < 40);
  endtask : poll
  // One transmit attempt on unit n, compared with the attempt counting model
  task automatic tx(input int n, input logic r);
    logic [3:0] code;
    logic exp_retry;
    int k;
    code = $random(seed);
    exp_retry = r && cnt[n] < lim[n];
    @(posedge clk);
    unit_tx_done <= 3'b001 << n;
    unit_ack_retryable <= {3{r}};
    unit_ack_code <= {3{code}};
    @(posedge clk);
    unit_tx_done <= 3'b000;
    k = 0;
    #1;
    while (unit_retry_req[n] !== 1'b1 && unit_final_valid[n] !== 1'b1 && k < 3) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("retry request", unit_retry_req[n], exp_retry);
    chk("packet closed", unit_final_valid[n], !exp_retry);
    if (!exp_retry) chk("final ack", unit_final_ack[4*n+:4], code);
    cnt[n] = exp_retry ? cnt[n] + 1 : 0;
  endtask : tx
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cs_op_done, cs_value_load, cs_new_value, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {unit_tx_done, unit_ack_retryable, unit_ack_code, ptr, last_byte} = '0;
    s_axi_wstrb = 4'hf;
    eeprom_detect = 1'b1;
    cnt = '{0, 0, 0};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd_reg(GER_OFS_VERSION);
    chk("present flag", rd[24], 1'b1);
    rd_reg(GER_OFS_RETRY);
    chk("retry reset", rd, 32'h0);
    $display("test presence done");
    // Clear, fetch, fetch again, then clear with a byte held: it must survive
    for (i = 0; i < 4; i++) begin
      if (i != 1) begin
        wr(GER_OFS_ID_ROM, 32'h8000_0000);
        poll(31);
        ptr = 8'h00;
        chk("word after clear", rd, id_word());
      end
      wr(GER_OFS_ID_ROM, 32'h0200_0000);
      poll(25);
      last_byte = rom_byte(ptr);
      ptr++;
      chk("word after fetch", rd, id_word());
    end
    chk("info loads", loads, 1);
    $display("test identifier rom done");
    // Random words: only the three limit nibbles may stick
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      if (i == 3) d = d & 32'hfffff333;
      wr(GER_OFS_RETRY, d);
      chk("retry write resp", rs, GER_RESP_OKAY);
      rd_reg(GER_OFS_RETRY);
      chk("retry limits", rd, d & 32'h0000_0fff);
    end
    for (u = 0; u < 3; u++) begin
      lim[u] = (d >> (4 * u)) & 32'hf;
      for (t = 0; t <= lim[u]; t++) tx(u, 1'b1);
      tx(u, 1'b0);
    end
    $display("test retry done");
    rd_reg(GER_OFS_CS_CTRL);
    chk("control reset", rd, 32'h8000_0000);
    for (i = 0; i < 4; i++) begin
      wr(GER_OFS_CS_CTRL, i);
      chk("resource select", bus_resource_select, i);
      rd_reg(GER_OFS_CS_CTRL);
      chk("control after write", rd, i);
    end
    @(posedge clk);
    cs_op_done <= 1'b1;
    cs_new_value <= $random(seed);
    cs_value_load <= 1'b1;
    @(posedge clk);
    {cs_op_done, cs_value_load} <= 2'b00;
    d = cs_new_value;
    rd_reg(GER_OFS_CS_CTRL);
    chk("finished flag", rd, 32'h8000_0003);
    chk("control writes", cs_writes, 4);
    wr(GER_OFS_CS_VALUE, ~d);
    rd_reg(GER_OFS_CS_VALUE);
    chk("swap value", rd, d);
    rd_reg(8'h10);
    chk("unmapped resp", rs, GER_RESP_SLVERR);
    chk("unmapped data", rd, 32'h0);
    wr(8'h1c, 32'hffff_ffff);
    chk("unmapped write", rs, GER_RESP_SLVERR);
    $display("test compare swap done");
    print_verdict();
  end
  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
